// ==== src/hub_port_status_display.sv ====
/*
  Front-panel status logic of a stackable repeater hub: port lamps,
  partitioning, repeat enables, error lamps, bar graphs and stack lamps,
  with a classic Wishbone slave for management software.
  Assumes all inputs synchronous to clk_i; frame and collision inputs are
  one-cycle pulses from the repeater core; port_rx_i is a level.
*/
`timescale 1ns/1ps
`include "hub_lamps_map.svh"

module hub_port_status_display #(
  parameter logic [24:0] WINDOW_CYC  = 25'(`WINDOW_MS * `CLK_KHZ),
  parameter logic [24:0] BLINK_CYC   = 25'(`BLINK_MS * `CLK_KHZ),
  parameter logic [24:0] STRETCH_CYC = 25'(`STRETCH_MS * `CLK_KHZ)
)(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 power_on_self_check_i,
  input  wire logic [`NPORT-1:0]    port_link_i,
  input  wire logic [`NPORT-1:0]    port_rx_i,
  input  wire logic [`NPORT-1:0]    port_col_i,
  input  wire logic [`NPORT-1:0]    port_line_err_i,
  input  wire logic [`NPORT-1:0]    port_rx_good_i,
  input  wire logic                 chain_rx_i,
  input  wire logic                 chain_in_present_i,
  input  wire logic                 chain_out_present_i,
  input  wire logic                 frame_done_i,
  input  wire logic [13:0]          frame_bits_i,
  input  wire logic                 frame_check_bad_i,
  input  wire logic                 other_err_i,
  input  wire logic                 col_i,
  input  wire logic [15:0]          col_bit_i,
  output logic [`NPORT-1:0]         port_green_o,
  output logic [`NPORT-1:0]         port_amber_o,
  output logic [`NPORT-1:0]         port_tx_o,
  output logic                      chain_tx_o,
  output logic                      master_lamp_o,
  output logic                      console_lamp_o,
  output logic                      oob_lamp_o,
  output logic                      frame_error_lamp_o,
  output logic                      late_col_lamp_o,
  output logic                      runt_lamp_o,
  output logic                      other_err_lamp_o,
  output logic                      col_lamp_o,
  output logic [`BAR_LAMPS-1:0]     util_bar_o,
  output logic [`BAR_LAMPS-1:0]     col_bar_o,
  output logic [3:0]                unit_number_display_o,
  output logic                      unit_display_on_o,
  output logic                      segmented_lamp_o,
  output logic                      chain_in_lamp_o,
  output logic                      chain_out_lamp_o
);

  localparam logic [24:0] UTIL_STEP = 25'(`LINK_KBPS * `WINDOW_MS / 8 / `BAR_LAMPS);
  localparam logic [24:0] COL_STEP  = 25'(`COL_PER_S_STEP * `WINDOW_MS / 1000);

  hub_lamps_pkg::hub_state_t s_reg;
  hub_lamps_pkg::hub_state_t s_next;

  logic [`NPORT-1:0]      src;
  logic                   fe_ev;
  logic                   runt_ev;
  logic                   late_ev;
  logic [`NEV-1:0]        ev;
  logic [`NEV-1:0]        held;
  logic [10:0]            util_add;
  logic [10:0]            col_add;
  logic [`BAR_LAMPS-1:0]  util_bar;
  logic [`BAR_LAMPS-1:0]  col_bar;
  logic [24:0]            util_total;
  logic [24:0]            col_total;

  // Byte-lane merge of a Wishbone write into a register image
  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Saturating event counter step
  function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic hit);
    return (hit && v != 8'hFF) ? v + 8'h01 : v;
  endfunction

  // Manual partition refuses incoming traffic, auto partition does not
  assign src = port_rx_i & ~s_reg.man_part;

  assign fe_ev   = frame_done_i && (frame_check_bad_i || frame_bits_i[2:0] != 3'h0);
  assign runt_ev = frame_done_i && (frame_bits_i[13:3] < `MIN_FRAME_BYTES);
  assign late_ev = col_i && (col_bit_i > `LATE_COL_BIT);
  assign ev = {col_i, other_err_i, late_ev, runt_ev, fe_ev, src};

  // Every frame counts toward utilisation, valid or not
  assign util_add = frame_done_i ? frame_bits_i[13:3] : 11'h000;
  assign col_add  = {10'h000, col_i};

  genvar gi;
  generate
    for (gi = 0; gi < `NEV; gi++) begin : g_stretch
      lamp_stretch #(
        .CYC (STRETCH_CYC)
      ) u_stretch (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ev_i  (ev[gi]),
        .on_o  (held[gi])
      );
    end
  endgenerate

  bar_meter #(
    .STEP (UTIL_STEP)
  ) u_util (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .win_i   (s_reg.win),
    .add_i   (util_add),
    .bar_o   (util_bar),
    .total_o (util_total)
  );

  bar_meter #(
    .STEP (COL_STEP)
  ) u_cols (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .win_i   (s_reg.win),
    .add_i   (col_add),
    .bar_o   (col_bar),
    .total_o (col_total)
  );

  always_comb begin
    logic [31:0] w;
    logic        acc;
    logic        others;
    w = 32'h00000000;
    acc = wb_cyc_i && wb_stb_i && !s_reg.ack;
    others = 1'b0;
    s_next = s_reg;

    // Timebases
    if (s_reg.blink_cnt >= BLINK_CYC - 25'h0000001) begin
      s_next.blink_cnt = 25'h0000000;
      s_next.blink = !s_reg.blink;
    end else begin
      s_next.blink_cnt = s_reg.blink_cnt + 25'h0000001;
    end
    s_next.win = 1'b0;
    if (s_reg.win_cnt >= WINDOW_CYC - 25'h0000001) begin
      s_next.win_cnt = 25'h0000000;
      s_next.win = 1'b1;
    end else begin
      s_next.win_cnt = s_reg.win_cnt + 25'h0000001;
    end

    // Self-check gate for the port lamps
    case (s_reg.mode)
      hub_lamps_pkg::MODE_SELFCHK: begin
        if (power_on_self_check_i) begin
          s_next.mode = hub_lamps_pkg::MODE_RUN;
        end
      end
      hub_lamps_pkg::MODE_RUN: begin
        s_next.mode = hub_lamps_pkg::MODE_RUN;
      end
      default: begin
        s_next.mode = hub_lamps_pkg::MODE_SELFCHK;
      end
    endcase

    // Auto partition; an error in the same cycle as a good packet wins
    for (int i = 0; i < `NPORT; i++) begin
      if (port_col_i[i] || port_line_err_i[i]) begin
        if (s_reg.err_cnt[i] != `ERR_LIMIT) begin
          s_next.err_cnt[i] = s_reg.err_cnt[i] + 5'h01;
        end
        if (s_reg.err_cnt[i] >= `ERR_LIMIT - 5'h01) begin
          s_next.auto_part[i] = 1'b1;
        end
      end else if (port_rx_good_i[i]) begin
        s_next.err_cnt[i] = 5'h00;
        s_next.auto_part[i] = 1'b0;
      end
    end

    // Repeat enables
    for (int i = 0; i < `NPORT; i++) begin
      others = ((src & ~(`NPORT'(1) << i)) != '0)
             || (chain_rx_i && !s_reg.ctrl[`CTRL_SEG]);
      s_next.port_tx[i] = others && port_link_i[i]
                        && !s_reg.auto_part[i] && !s_reg.man_part[i];
    end
    s_next.chain_tx = (src != '0) && !s_reg.ctrl[`CTRL_SEG];

    // Port lamps, highest priority first
    for (int i = 0; i < `NPORT; i++) begin
      s_next.green[i] = 1'b0;
      s_next.amber[i] = 1'b0;
      if (s_reg.mode != hub_lamps_pkg::MODE_RUN) begin
        s_next.green[i] = 1'b1;
      end else if (s_reg.man_part[i]) begin
        s_next.amber[i] = 1'b1;
      end else if (s_reg.auto_part[i]) begin
        s_next.amber[i] = s_reg.blink;
      end else if (port_link_i[i] && held[i]) begin
        s_next.green[i] = s_reg.blink;
      end else begin
        s_next.green[i] = port_link_i[i];
      end
    end

    // Unit lamps
    s_next.master = s_reg.ctrl[`CTRL_MASTER];
    s_next.con = !s_reg.ctrl[`CTRL_SLIP];
    s_next.oob = s_reg.ctrl[`CTRL_SLIP];
    s_next.fe = held[`NPORT];
    s_next.runt = held[`NPORT+1];
    s_next.lc = held[`NPORT+2];
    s_next.oth = held[`NPORT+3];
    s_next.col = held[`NPORT+4] && s_reg.blink;
    s_next.unit_num = s_reg.unit;
    s_next.unit_on = !s_reg.ctrl[`CTRL_LOCATE] || s_reg.blink;
    s_next.seg = s_reg.ctrl[`CTRL_SEG];
    s_next.in_arrow = chain_in_present_i;
    s_next.out_arrow = chain_out_present_i;

    // Error tallies; a hit in the clearing cycle is kept
    for (int k = 0; k < 4; k++) begin
      s_next.ev_cnt[k] = sat_inc(s_reg.ev_cnt[k], ev[`NPORT + k]);
    end

    // Wishbone slave: one access per request, answer on the next edge
    s_next.ack = acc;
    if (acc) begin
      s_next.dat = 32'h00000000;
      if (wb_we_i) begin
        case ({wb_adr_i[7:2], 2'h0})
          `REG_CTRL: begin
            w = wb_merge({28'h0000000, s_reg.ctrl}, wb_dat_i, wb_sel_i);
            s_next.ctrl = w[3:0];
          end
          `REG_UNIT: begin
            w = wb_merge({28'h0000000, s_reg.unit}, wb_dat_i, wb_sel_i);
            s_next.unit = w[3:0];
          end
          `REG_MANPART: begin
            w = wb_merge({20'h00000, s_reg.man_part}, wb_dat_i, wb_sel_i);
            s_next.man_part = w[`NPORT-1:0];
          end
          `REG_ERRCNT: begin
            for (int k = 0; k < 4; k++) begin
              if (wb_sel_i[k]) begin
                s_next.ev_cnt[k] = ev[`NPORT + k] ? 8'h01 : 8'h00;
              end
            end
          end
          default: begin
            s_next.dat = 32'h00000000;
          end
        endcase
      end else begin
        case ({wb_adr_i[7:2], 2'h0})
          `REG_CTRL:     s_next.dat = {28'h0000000, s_reg.ctrl};
          `REG_UNIT:     s_next.dat = {28'h0000000, s_reg.unit};
          `REG_MANPART:  s_next.dat = {20'h00000, s_reg.man_part};
          `REG_AUTOPART: s_next.dat = {20'h00000, s_reg.auto_part};
          `REG_LINK:     s_next.dat = {20'h00000, port_link_i};
          `REG_UTIL:     s_next.dat = {7'h00, util_total};
          `REG_COLS:     s_next.dat = {7'h00, col_total};
          `REG_ERRCNT:   s_next.dat = s_reg.ev_cnt;
          default:       s_next.dat = 32'h00000000;
        endcase
      end
    end
  end

  // Struct reset also clears lamp and bus outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.mode <= hub_lamps_pkg::MODE_SELFCHK;
      s_reg.ctrl <= `CTRL_RST;
      s_reg.unit <= `UNIT_RST;
      s_reg.man_part <= `MANPART_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_dat_o = s_reg.dat;
  assign wb_ack_o = s_reg.ack;
  assign port_green_o = s_reg.green;
  assign port_amber_o = s_reg.amber;
  assign port_tx_o = s_reg.port_tx;
  assign chain_tx_o = s_reg.chain_tx;
  assign master_lamp_o = s_reg.master;
  assign console_lamp_o = s_reg.con;
  assign oob_lamp_o = s_reg.oob;
  assign frame_error_lamp_o = s_reg.fe;
  assign late_col_lamp_o = s_reg.lc;
  assign runt_lamp_o = s_reg.runt;
  assign other_err_lamp_o = s_reg.oth;
  assign col_lamp_o = s_reg.col;
  assign util_bar_o = util_bar;
  assign col_bar_o = col_bar;
  assign unit_number_display_o = s_reg.unit_num;
  assign unit_display_on_o = s_reg.unit_on;
  assign segmented_lamp_o = s_reg.seg;
  assign chain_in_lamp_o = s_reg.in_arrow;
  assign chain_out_lamp_o = s_reg.out_arrow;

endmodule

// ==== inc/hub_lamps_map.svh ====
/*
  Constants for the hub status display: register offsets, control bit
  positions, reset values, thresholds and timing figures.
  Assumes a 50 MHz system clock and a 10 Mbps shared medium.
*/
`ifndef HUB_LAMPS_MAP_SVH
`define HUB_LAMPS_MAP_SVH

`define NPORT          12
`define NEV            (`NPORT + 5)
`define BAR_LAMPS      8

// Register byte offsets
`define REG_CTRL       8'h00
`define REG_UNIT       8'h04
`define REG_MANPART    8'h08
`define REG_AUTOPART   8'h0C
`define REG_LINK       8'h10
`define REG_UTIL       8'h14
`define REG_COLS       8'h18
`define REG_ERRCNT     8'h1C

// Control register bits
`define CTRL_MASTER    0
`define CTRL_SLIP      1
`define CTRL_SEG       2
`define CTRL_LOCATE    3

// Reset values
`define CTRL_RST       4'h0
`define UNIT_RST       4'h0
`define MANPART_RST    12'h000

// Thresholds
`define ERR_LIMIT      5'h1F
`define LATE_COL_BIT   16'h0200
`define MIN_FRAME_BYTES 11'h040

// Timing, in milliseconds, kilo-units and collisions per second
`define CLK_KHZ        50000
`define WINDOW_MS      500
`define BLINK_MS       250
`define STRETCH_MS     50
`define LINK_KBPS      10000
`define COL_PER_S_STEP 10

`endif

// ==== inc/hub_lamps_pkg.sv ====
/*
  Types for the hub status display: mode enumeration and the state
  structs of each module. Assumes hub_lamps_map.svh on the include path.
*/
`include "hub_lamps_map.svh"

package hub_lamps_pkg;

  typedef enum logic [1:0] {
    MODE_SELFCHK = 2'h0,
    MODE_RUN     = 2'h1
  } mode_t;

  typedef struct packed {
    logic [24:0] cnt;
  } stretch_state_t;

  typedef struct packed {
    logic [24:0]            acc;
    logic [24:0]            total;
    logic [`BAR_LAMPS-1:0]  bar;
  } meter_state_t;

  typedef struct packed {
    mode_t                      mode;
    logic [24:0]                blink_cnt;
    logic                       blink;
    logic [24:0]                win_cnt;
    logic                       win;
    logic [3:0]                 ctrl;
    logic [3:0]                 unit;
    logic [`NPORT-1:0]          man_part;
    logic [`NPORT-1:0]          auto_part;
    logic [`NPORT-1:0][4:0]     err_cnt;
    logic [3:0][7:0]            ev_cnt;
    logic [`NPORT-1:0]          green;
    logic [`NPORT-1:0]          amber;
    logic [`NPORT-1:0]          port_tx;
    logic                       chain_tx;
    logic                       master;
    logic                       con;
    logic                       oob;
    logic                       fe;
    logic                       lc;
    logic                       runt;
    logic                       oth;
    logic                       col;
    logic [3:0]                 unit_num;
    logic                       unit_on;
    logic                       seg;
    logic                       in_arrow;
    logic                       out_arrow;
    logic                       ack;
    logic [31:0]                dat;
  } hub_state_t;

endpackage

// ==== src/lamp_stretch.sv ====
/*
  Stretches a pulse or level to a minimum visible on-time.
  Assumes the event input is synchronous to clk_i.
*/
`timescale 1ns/1ps
`include "hub_lamps_map.svh"

module lamp_stretch #(
  parameter logic [24:0] CYC = 25'h0000001
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ev_i,
  output logic      on_o
);

  hub_lamps_pkg::stretch_state_t s_reg;
  hub_lamps_pkg::stretch_state_t s_next;

  always_comb begin
    s_next = s_reg;
    if (ev_i) begin
      s_next.cnt = CYC;
    end else if (s_reg.cnt != 25'h0000000) begin
      s_next.cnt = s_reg.cnt - 25'h0000001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign on_o = (s_reg.cnt != 25'h0000000);

endmodule

// ==== src/bar_meter.sv ====
/*
  Accumulates an amount over a measuring window and latches a thermometer
  bar and the window total at each window pulse.
  Assumes win_i is a one-cycle pulse from the parent's window timer.
*/
`timescale 1ns/1ps
`include "hub_lamps_map.svh"

module bar_meter #(
  parameter logic [24:0] STEP = 25'h0000001
)(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  win_i,
  input  wire logic [10:0]           add_i,
  output logic [`BAR_LAMPS-1:0]      bar_o,
  output logic [24:0]                total_o
);

  hub_lamps_pkg::meter_state_t s_reg;
  hub_lamps_pkg::meter_state_t s_next;

  always_comb begin
    logic [24:0] sum;
    sum = s_reg.acc + {14'h0000, add_i};
    s_next = s_reg;
    s_next.acc = sum;
    if (win_i) begin
      s_next.acc = 25'h0000000;
      s_next.total = sum;
      for (int k = 0; k < `BAR_LAMPS; k++) begin
        s_next.bar[k] = (sum >= 25'(STEP * 25'(k + 1)));
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bar_o = s_reg.bar;
  assign total_o = s_reg.total;

endmodule

// ==== testbench/hub_display_checker_asserts.sv ====
/*
  Concurrent checks on the status display ports: bus answer, self-check lamps,
  console lamps, error lamps, chain arrows and segment isolation.
  Assumes the test values of the timing parameters and registered outputs.
*/
`timescale 1ns/1ps
`include "hub_lamps_map.svh"
module hub_display_checker (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_ack_o,
  input wire logic              power_on_self_check_i,
  input wire logic [`NPORT-1:0] port_green_o,
  input wire logic              console_lamp_o,
  input wire logic              oob_lamp_o,
  input wire logic              frame_done_i,
  input wire logic [13:0]       frame_bits_i,
  input wire logic              frame_check_bad_i,
  input wire logic              col_i,
  input wire logic [15:0]       col_bit_i,
  input wire logic              col_lamp_o,
  input wire logic              other_err_i,
  input wire logic              frame_error_lamp_o,
  input wire logic              late_col_lamp_o,
  input wire logic              runt_lamp_o,
  input wire logic              other_err_lamp_o,
  input wire logic              chain_in_present_i,
  input wire logic              chain_out_present_i,
  input wire logic              chain_in_lamp_o,
  input wire logic              chain_out_lamp_o,
  input wire logic              segmented_lamp_o,
  input wire logic              chain_tx_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       seen_reg;
  logic [1:0] live_reg;
  // Outputs are only meaningful two edges after reset leaves
  always_ff @(posedge clk_i) begin
    seen_reg <= rst_i ? 1'b0 : (seen_reg | power_on_self_check_i);
    live_reg <= rst_i ? 2'h0 : {live_reg[0], 1'b1};
  end
  wb_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  selfchk_lit_a: assert property (live_reg[1] && !seen_reg |-> &port_green_o)
    else $error("port lamps dark during self check");
  console_mode_a: assert property (live_reg[1] |-> console_lamp_o != oob_lamp_o)
    else $error("console lamps not exclusive");
  frame_err_a: assert property (frame_done_i && (frame_check_bad_i || frame_bits_i[2:0] != 3'h0)
    |-> ##2 frame_error_lamp_o)
    else $error("frame error lamp missing");
  late_col_a: assert property (col_i && col_bit_i > 16'h0200 |-> ##2 late_col_lamp_o)
    else $error("late collision lamp missing");
  runt_lamp_a: assert property (frame_done_i && frame_bits_i < 14'h0200 |-> ##2 runt_lamp_o)
    else $error("short frame lamp missing");
  other_lamp_a: assert property (other_err_i |-> ##2 other_err_lamp_o [*3])
    else $error("other error lamp not held");
  chain_arrow_a: assert property (live_reg[1] |-> chain_in_lamp_o == $past(chain_in_present_i)
    && chain_out_lamp_o == $past(chain_out_present_i))
    else $error("chain arrow lamps wrong");
  seg_isolate_a: assert property (segmented_lamp_o |-> !chain_tx_o)
    else $error("segmented hub repeats to chain");
  // Stretch of four cycles: the lamp may only show two to five edges after a collision
  col_blink_a: assert property (col_lamp_o |-> $past(col_i, 2) || $past(col_i, 3)
    || $past(col_i, 4) || $past(col_i, 5))
    else $error("collision lamp lit without a collision");
  cover property (other_err_i ##2 other_err_lamp_o);
  cover property (segmented_lamp_o);
  cover property (col_i && col_bit_i > 16'h0200);
endmodule
bind hub_port_status_display hub_display_checker hub_display_checker_inst (.*);

// ==== testbench/eth_stations.sv ====
/*
  Stations on the twisted-pair ports: link levels, receive levels,
  collision and line error pulses, valid packet pulses.
  Assumes the bench calls its tasks; all changes follow a rising edge.
*/
`timescale 1ns/1ps
`include "hub_lamps_map.svh"
module eth_stations (
  input  wire logic              clk_i,
  output logic [`NPORT-1:0]      port_link_i,
  output logic [`NPORT-1:0]      port_rx_i,
  output logic [`NPORT-1:0]      port_col_i,
  output logic [`NPORT-1:0]      port_line_err_i,
  output logic [`NPORT-1:0]      port_rx_good_i
);
  initial begin
    {port_link_i, port_rx_i, port_col_i, port_line_err_i, port_rx_good_i} = '0;
  end
  task link(input logic [`NPORT-1:0] m);
    @(posedge clk_i);
    port_link_i <= m;
  endtask
  task rx(input int p, input logic v);
    @(posedge clk_i);
    port_rx_i[p] <= v;
  endtask
  // Collisions and line errors alternate, so both kinds feed the tally
  task errs(input int p, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      if (i % 2 == 1) port_line_err_i[p] <= 1'b1;
      else port_col_i[p] <= 1'b1;
      @(posedge clk_i);
      port_col_i[p] <= 1'b0;
      port_line_err_i[p] <= 1'b0;
    end
  endtask
  task good(input int p);
    @(posedge clk_i);
    port_rx_good_i[p] <= 1'b1;
    @(posedge clk_i);
    port_rx_good_i[p] <= 1'b0;
  endtask
endmodule

// ==== testbench/hub_port_status_display_bench.sv ====
/*
  Self-checking bench for the hub status display: Wishbone register access,
  port lamps, partitioning, repeat enables, error tallies and bar graphs.
  Assumes short test timing: window 100, blink 8, stretch 4 cycles.
*/
`timescale 1ns/1ps
`include "hub_lamps_map.svh"
module hub_port_status_display_bench;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic power_on_self_check_i, chain_rx_i, chain_in_present_i, chain_out_present_i;
  logic frame_done_i, frame_check_bad_i, other_err_i, col_i, chain_tx_o;
  logic master_lamp_o, console_lamp_o, oob_lamp_o, frame_error_lamp_o, late_col_lamp_o;
  logic runt_lamp_o, other_err_lamp_o, col_lamp_o, unit_display_on_o;
  logic segmented_lamp_o, chain_in_lamp_o, chain_out_lamp_o;
  logic [7:0]            wb_adr_i;
  logic [3:0]            wb_sel_i, unit_number_display_o, mon, mo, ma;
  logic [31:0]           wb_dat_i, wb_dat_o, q;
  logic [13:0]           frame_bits_i;
  logic [15:0]           col_bit_i;
  logic [`NPORT-1:0]     port_link_i, port_rx_i, port_col_i, port_line_err_i, port_rx_good_i;
  logic [`NPORT-1:0]     port_green_o, port_amber_o, port_tx_o;
  logic [`BAR_LAMPS-1:0] util_bar_o, col_bar_o;
  int                    bad_count = 0;
  int                    samples_checked = 0;
  assign mon = {unit_display_on_o, port_amber_o[2], port_green_o[0], port_amber_o[1] | col_lamp_o};
  hub_port_status_display #(.WINDOW_CYC(25'h64), .BLINK_CYC(25'h8), .STRETCH_CYC(25'h4))
    hub_port_status_display_inst (.*);
  eth_stations eth_stations_inst (.*);
  task complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One classic cycle; the master waits for ack, bounded
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, s};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      complete_run();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
    repeat (2) @(posedge clk_i);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(q, e);
  endtask
  // Records whether each watched lamp was ever on and always on
  task watch(input int n);
    mo = 4'h0;
    ma = 4'hF;
    repeat (n) begin
      @(posedge clk_i);
      mo = mo | mon;
      ma = ma & mon;
    end
  endtask
  task frame(input logic [13:0] b, input logic bad);
    @(posedge clk_i);
    {frame_done_i, frame_bits_i, frame_check_bad_i} <= {1'b1, b, bad};
    @(posedge clk_i);
    frame_done_i <= 1'b0;
  endtask
  task col(input logic [15:0] p);
    @(posedge clk_i);
    {col_i, col_bit_i} <= {1'b1, p};
    @(posedge clk_i);
    col_i <= 1'b0;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    complete_run();
  end
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, power_on_self_check_i, chain_rx_i, chain_in_present_i} = '0;
    {chain_out_present_i, frame_done_i, frame_check_bad_i, other_err_i, col_i} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, frame_bits_i, col_bit_i} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(32'(port_green_o), 32'hFFF);
    power_on_self_check_i <= 1'b1;
    eth_stations_inst.link(12'h007);
    repeat (4) @(posedge clk_i);
    chk(32'(port_green_o), 32'h007);
    rd(8'h00, 32'h0);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h7);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, 32'h1 << i);
      chk(32'({master_lamp_o, console_lamp_o, oob_lamp_o, segmented_lamp_o}),
          32'(4'(12'h52C >> (4 * i))));
      rd(8'h00, 32'h1 << i);
    end
    wr(8'h00, 32'h0);
    // Chain traffic goes to every linked, unpartitioned port unless segmented, never back to the chain
    chain_rx_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(32'({chain_tx_o, port_tx_o}), 32'h0007);
    wr(8'h00, 32'h4);
    chk(32'(port_tx_o), 32'h000);
    chain_rx_i <= 1'b0;
    wr(8'h00, 32'h0);
    eth_stations_inst.rx(0, 1'b1);
    watch(20);
    chk(32'({chain_tx_o, port_tx_o}), 32'h1006);
    chk(32'({mo[1], ma[1]}), 32'h2);
    wr(8'h00, 32'h4);
    chk(32'({chain_tx_o, port_tx_o}), 32'h0006);
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h2);
    watch(20);
    chk(32'(port_tx_o), 32'h004);
    chk(32'(ma[0]), 32'h1);
    eth_stations_inst.rx(0, 1'b0);
    eth_stations_inst.rx(1, 1'b1);
    repeat (3) @(posedge clk_i);
    chk(32'({chain_tx_o, port_tx_o}), 32'h0);
    eth_stations_inst.rx(1, 1'b0);
    wr(8'h08, 32'h0);
    eth_stations_inst.errs(2, 31);
    rd(8'h0C, 32'h4);
    eth_stations_inst.rx(0, 1'b1);
    watch(20);
    chk(32'(port_tx_o), 32'h002);
    chk(32'({mo[2], ma[2]}), 32'h2);
    eth_stations_inst.rx(0, 1'b0);
    eth_stations_inst.rx(2, 1'b1);
    repeat (3) @(posedge clk_i);
    chk(32'(port_tx_o), 32'h003);
    eth_stations_inst.rx(2, 1'b0);
    eth_stations_inst.good(2);
    rd(8'h0C, 32'h0);
    wr(8'h04, 32'h5);
    wr(8'h00, 32'h8);
    watch(20);
    chk(32'({unit_number_display_o, mo[3], ma[3]}), 32'h16);
    wr(8'h00, 32'h0);
    chain_in_present_i <= 1'b1;
    wr(8'h1C, 32'h0);
    frame(14'h03E8, 1'b1);
    frame(14'h03E9, 1'b0);
    frame(14'h01F8, 1'b0);
    frame(14'h0200, 1'b0);
    col(16'h0201);
    col(16'h0200);
    other_err_i <= 1'b1;
    @(posedge clk_i);
    other_err_i <= 1'b0;
    rd(8'h1C, 32'h01010102);
    chk(32'({chain_in_lamp_o, chain_out_lamp_o}), 32'h2);
    @(posedge clk_i);
    {frame_done_i, col_i, frame_check_bad_i} <= 3'h6;
    {frame_bits_i, col_bit_i} <= {14'h3E80, 16'h0000};
    fork
      repeat (250) @(posedge clk_i);
      begin
        repeat (220) @(posedge clk_i);
        chk(32'({util_bar_o, col_bar_o}), 32'h03FF);
        rd(8'h14, 32'h00030D40);
        rd(8'h18, 32'h64);
        watch(20);
        chk(32'({mo[0], ma[0]}), 32'h2);
      end
    join
    {frame_done_i, col_i} <= 2'h0;
    wb(1'b1, 8'h1C, 32'h0, 4'h1);
    rd(8'h1C, 32'h01010100);
    complete_run();
  end
endmodule
